// *** pth_pkg.sv ***
// Package for the period timer with hardware limit: constants and types
package pth_pkg;

  localparam int          CNT_W      = 8;
  localparam int          PRE_W      = 3;
  localparam int          POST_W     = 4;
  localparam int          MODE_W     = 5;
  localparam int          SRC_W      = 4;
  localparam int          PRE_CNT_W  = 7;
  localparam logic [7:0]  COUNT_RST  = 8'h00;
  localparam logic [7:0]  PERIOD_RST = 8'hFF;
  localparam logic [6:0]  PRE_ZERO   = 7'h00;
  localparam logic [3:0]  POST_ZERO  = 4'h0;
  localparam logic [6:0]  PRE_ONE    = 7'h01;
  localparam logic [3:0]  POST_ONE   = 4'h1;
  localparam logic [7:0]  COUNT_ONE  = 8'h01;

  // Major operation, upper two mode bits
  typedef enum logic [1:0] {
    PTH_FREE    = 2'b00,
    PTH_ONESHOT = 2'b01,
    PTH_MONO    = 2'b10,
    PTH_RSVD    = 2'b11
  } pth_major_e;

  // Timer control register contents
  typedef struct packed {
    logic              run_enable;
    logic [PRE_W-1:0]  prescale_select;
    logic [POST_W-1:0] postscale_select;
  } pth_ctrl_s;

  // Software write port for count and period
  typedef struct packed {
    logic             count_we;
    logic             period_we;
    logic [CNT_W-1:0] wdata;
  } pth_wr_s;

endpackage

// *** pth_timer.sv ***
// Period timer with hardware limit, prescaler and postscaler
`timescale 1ns/100ps
module pth_timer
  import pth_pkg::*;
#(
  parameter int SRC_N = 16
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire pth_ctrl_s            timer_control_reg,
  input  wire logic                 ctrl_we,
  input  wire pth_wr_s              sw_wr,
  input  wire logic [MODE_W-1:0]    hw_limit_control_reg,
  input  wire logic [SRC_W-1:0]     ext_reset_source_select,
  input  wire logic [SRC_N-1:0]     ext_sources,
  input  wire logic                 debug_freeze,
  output logic                      run_enable_clr,
  output logic [CNT_W-1:0]          count_value,
  output logic [CNT_W-1:0]          period_value,
  output logic                      period_pulse_out,
  output logic                      period_match,
  output logic                      timer_tick
);

  // ****************************************
  // Synchronisers
  // ****************************************
  logic             run_s1_q, run_s2_q, ers_prev_q;
  logic [SRC_N-1:0] src_s1_q, src_s2_q;
  logic             ers_sel;

  // Pick the source only after both sync stages, so no logic sees a raw pin
  assign ers_sel = src_s2_q[ext_reset_source_select];

  // Two stage sync of run enable and external signal
  always_ff @(posedge clock) begin
    if (rst) begin
      run_s1_q   <= 1'b0;
      run_s2_q   <= 1'b0;
      src_s1_q   <= '0;
      src_s2_q   <= '0;
      ers_prev_q <= 1'b0;
    end else begin
      run_s1_q   <= timer_control_reg.run_enable;
      run_s2_q   <= run_s1_q;
      src_s1_q   <= ext_sources;
      src_s2_q   <= src_s1_q;
      ers_prev_q <= ers_sel;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  pth_major_e major;
  logic [2:0] sub;
  logic       ers, rise, fall, anye, start_ev, hw_rst, gate_ok, edge_start;

  assign major = pth_major_e'(hw_limit_control_reg[4:3]);
  assign sub   = hw_limit_control_reg[2:0];
  assign ers   = ers_sel;
  assign rise  = ~debug_freeze & ers & ~ers_prev_q;
  assign fall  = ~debug_freeze & ~ers & ers_prev_q;

  // Start, gate and reset conditions per mode
  always_comb begin
    anye       = rise | fall;
    gate_ok    = 1'b1;
    hw_rst     = 1'b0;
    start_ev   = 1'b0;
    edge_start = 1'b0;
    case (major)
      PTH_FREE: begin
        case (sub)
          3'b000: gate_ok = 1'b1;
          3'b001: gate_ok = debug_freeze | ers;
          3'b010: gate_ok = debug_freeze | ~ers;
          3'b011: hw_rst  = anye;
          3'b100: hw_rst  = rise;
          3'b101: hw_rst  = fall;
          3'b110: hw_rst  = ~debug_freeze & ~ers;
          3'b111: hw_rst  = ~debug_freeze & ers;
          default: gate_ok = 1'b1;
        endcase
      end
      PTH_ONESHOT, PTH_MONO: begin
        edge_start = 1'b1;
        case (sub)
          3'b001: start_ev = rise;
          3'b010: start_ev = fall;
          3'b011: start_ev = anye;
          3'b100: begin start_ev = rise; hw_rst = rise; end
          3'b101: begin start_ev = fall; hw_rst = fall; end
          3'b110: begin start_ev = rise; hw_rst = ~debug_freeze & ~ers; end
          3'b111: begin start_ev = fall; hw_rst = ~debug_freeze & ers; end
          default: begin edge_start = 1'b0; start_ev = 1'b0; end
        endcase
        if (major == PTH_MONO && sub > 3'b011) begin
          edge_start = 1'b0; // Reserved monostable codes
          hw_rst     = 1'b0;
        end
      end
      default: begin
        gate_ok = 1'b0;
      end
    endcase
  end

  logic mode_ok;
  assign mode_ok = ~((major == PTH_RSVD) |
                     (major == PTH_MONO && (sub == 3'b000 || sub > 3'b011)));

  // ****************************************
  // Prescaler
  // ****************************************
  logic [PRE_CNT_W-1:0] pre_q;
  logic [PRE_CNT_W-1:0] pre_last;
  logic                 tick, clr_scalers, armed_q, running;

  assign pre_last = PRE_CNT_W'((8'h01 << timer_control_reg.prescale_select) - 8'h01);
  assign tick     = (pre_q >= pre_last);

  // Prescale counter, cleared on control and count writes and on resets
  always_ff @(posedge clock) begin
    if (rst || clr_scalers) begin
      pre_q <= PRE_ZERO;
    end else if (running) begin
      pre_q <= tick ? PRE_ZERO : pre_q + PRE_ONE;
    end
  end

  // ****************************************
  // Run state
  // ****************************************
  logic stopped_q, prev_run_q;
  logic match;

  assign match   = tick & (count_value == period_value);
  assign running = run_s2_q & armed_q & ~stopped_q & gate_ok & mode_ok &
                   ~(hw_rst & ~edge_start);
  assign clr_scalers = ctrl_we | sw_wr.count_we | (hw_rst & run_s2_q);

  // Arm on enable, waiting for a fresh edge in edge-start modes
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_q    <= 1'b0;
      stopped_q  <= 1'b0;
      prev_run_q <= 1'b0;
    end else begin
      prev_run_q <= run_s2_q;
      if (!run_s2_q) begin
        armed_q   <= 1'b0;
        stopped_q <= 1'b0;
      end else if (!prev_run_q) begin
        armed_q   <= ~edge_start;
        stopped_q <= 1'b0;
      end else if (edge_start && start_ev && (!armed_q || stopped_q)) begin
        armed_q   <= 1'b1;
        stopped_q <= 1'b0;
      end else if (running && match && major != PTH_FREE) begin
        stopped_q <= 1'b1;
      end
    end
  end

  // Software clear request for run enable in one-shot
  always_ff @(posedge clock) begin
    if (rst) begin
      run_enable_clr <= 1'b0;
    end else begin
      run_enable_clr <= running & match & (major == PTH_ONESHOT);
    end
  end

  // ****************************************
  // Count and period
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      count_value <= COUNT_RST;
    end else if (sw_wr.count_we) begin
      count_value <= sw_wr.wdata;
    end else if (hw_rst && run_s2_q) begin
      count_value <= COUNT_RST;
    end else if (running && tick) begin
      count_value <= match ? COUNT_RST : count_value + COUNT_ONE;
    end
  end

  // Period register
  always_ff @(posedge clock) begin
    if (rst) begin
      period_value <= PERIOD_RST;
    end else if (sw_wr.period_we) begin
      period_value <= sw_wr.wdata;
    end
  end

  // ****************************************
  // Postscaler
  // ****************************************
  logic [POST_W-1:0] post_q;
  logic              restart;

  assign restart = edge_start & start_ev & run_s2_q & (~armed_q | stopped_q);

  // Count period matches and fire on select
  always_ff @(posedge clock) begin
    if (rst || clr_scalers || restart || (run_s2_q && !prev_run_q)) begin
      post_q           <= POST_ZERO;
      period_pulse_out <= 1'b0;
    end else if (running && match) begin
      if (post_q == timer_control_reg.postscale_select) begin
        post_q           <= POST_ZERO;
        period_pulse_out <= 1'b1;
      end else begin
        post_q           <= post_q + POST_ONE;
        period_pulse_out <= 1'b0;
      end
    end else begin
      period_pulse_out <= 1'b0;
    end
  end

  // Registered timing signals for PWM logic
  always_ff @(posedge clock) begin
    if (rst) begin
      period_match <= 1'b0;
      timer_tick   <= 1'b0;
    end else begin
      period_match <= running & match;
      timer_tick   <= running & tick;
    end
  end

endmodule // pth_timer

// *** pth_timer_chk_sva.sv ***
// Assertion checker for the period timer
`timescale 1ns/100ps
module pth_timer_chk
  import pth_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire pth_wr_s           sw_wr,
  input wire logic [MODE_W-1:0] hw_limit_control_reg,
  input wire logic              run_enable_clr,
  input wire logic [CNT_W-1:0]  count_value,
  input wire logic [CNT_W-1:0]  period_value,
  input wire logic              period_pulse_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Reserved mode held for three clocks with no count write
  sequence s_rsvd_held;
    (hw_limit_control_reg[4:3] == 2'b11 && !sw_wr.count_we) [*3];
  endsequence
  property p_rst_vals;
    $fell(rst) |-> count_value == 8'h00 && period_value == 8'hFF;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_wr_cnt;
    sw_wr.count_we |=> count_value == $past(sw_wr.wdata);
  endproperty
  a_wr_cnt: assert property (p_wr_cnt) else $error("count write lost");
  property p_wr_per;
    sw_wr.period_we |=> period_value == $past(sw_wr.wdata);
  endproperty
  a_wr_per: assert property (p_wr_per) else $error("period write lost");
  property p_step;
    !$past(sw_wr.count_we) && $changed(count_value)
      |-> count_value == $past(count_value) + 8'h01 || count_value == 8'h00;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_wrap;
    $past(count_value) == $past(period_value) && $changed(count_value)
      && !$past(sw_wr.count_we) |-> count_value == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at period");
  property p_rsvd;
    s_rsvd_held |=> $stable(count_value);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode counts");
  property p_pulse;
    period_pulse_out && period_value != 8'h00 |=> !period_pulse_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too wide");
  property p_os_clr;
    run_enable_clr |-> hw_limit_control_reg[4:3] == 2'b01;
  endproperty
  a_os_clr: assert property (p_os_clr) else $error("enable cleared");
endmodule // pth_timer_chk

// *** pth_ers_model.sv ***
// Model of the logic that drives the external reset candidates
`timescale 1ns/100ps
module pth_ers_model #(
  parameter int SRC_N = 16,
  parameter int SEL   = 5
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        want_level,
  output logic [SRC_N-1:0] ext_sources
);
  logic       level_q;
  logic [2:0] hold_q;
  logic       junk_q;
  // Change the selected level only after six ticks of holding
  always_ff @(posedge clock) begin
    if (rst) begin
      level_q <= 1'b0;
      hold_q  <= 3'h0;
    end else if (want_level != level_q && hold_q == 3'h6) begin
      level_q <= want_level;
      hold_q  <= 3'h0;
    end else if (hold_q != 3'h6) begin
      hold_q <= hold_q + 3'h1;
    end
  end
  // Unselected candidates toggle, so a wrong pick shows up
  always_ff @(posedge clock) begin
    if (rst) begin
      junk_q <= 1'b0;
    end else begin
      junk_q <= !junk_q;
    end
  end
  always_comb begin
    ext_sources      = {SRC_N{junk_q}};
    ext_sources[SEL] = level_q;
  end
endmodule // pth_ers_model

// *** test_pth_timer.sv ***
// Self-checking testbench for the period timer
`timescale 1ns/100ps
module test_pth_timer;
  import pth_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ctrl_we = 1'b0;
  logic        debug_freeze = 1'b0;
  logic        want_level = 1'b0;
  pth_ctrl_s   ctrl = '0;
  pth_wr_s     sw_wr = '0;
  logic [4:0]  mode = 5'h00;
  logic [15:0] ext_sources;
  logic [7:0]  count_value;
  logic [7:0]  period_value;
  logic        run_enable_clr, period_pulse_out, period_match, timer_tick;
  int          fails = 0;
  int          n_checks = 0;
  int          n;
  always #10 clock = ~clock;
  pth_ers_model u_pth_ers_model (.clock(clock), .rst(rst), .want_level(want_level),
    .ext_sources(ext_sources));
  pth_timer u_pth_timer (.clock(clock), .rst(rst), .timer_control_reg(ctrl),
    .ctrl_we(ctrl_we), .sw_wr(sw_wr), .hw_limit_control_reg(mode),
    .ext_reset_source_select(4'h5), .ext_sources(ext_sources),
    .debug_freeze(debug_freeze), .run_enable_clr(run_enable_clr),
    .count_value(count_value), .period_value(period_value),
    .period_pulse_out(period_pulse_out), .period_match(period_match),
    .timer_tick(timer_tick));
  task automatic end_sim();
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // Program mode and control; the control write strobe lasts one clock
  task automatic cfg(input logic [4:0] m, input logic [2:0] pre, input logic [3:0] post,
                     input logic on);
    mode = m;
    ctrl = '{on, pre, post};
    ctrl_we = 1'b1;
    step(1);
    ctrl_we = 1'b0;
  endtask
  task automatic wr(input logic c, input logic p, input logic [7:0] d);
    sw_wr = '{c, p, d};
    step(1);
    sw_wr = '0;
  endtask
  // Clocks until the next pulse (sel 0) or enable clear (sel 1), bounded
  task automatic wait_ev(input logic sel);
    n = 0;
    do begin
      step(1);
      n++;
      if (n > 5000) begin
        fails++;
        end_sim();
      end
    end while ((sel ? run_enable_clr : period_pulse_out) !== 1'b1);
  endtask
  // Pulse spacing over prescale and postscale corners, period 2
  task automatic t_scale();
    logic [2:0] pre [4] = '{3'h0, 3'h2, 3'h7, 3'h0};
    logic [3:0] pst [4] = '{4'h0, 4'h1, 4'h0, 4'hF};
    for (int i = 0; i < 4; i++) begin
      cfg(5'h00, pre[i], pst[i], 1'b1);
      wait_ev(1'b0);
      wait_ev(1'b0);
      check(16'(n), 16'(3 * (1 << pre[i]) * (pst[i] + 1)));
      cfg(5'h00, 3'h0, 4'h0, 1'b0);
    end
  endtask
  // One-shot stops at zero; reserved mode never counts
  task automatic t_oneshot();
    cfg(5'h08, 3'h0, 4'h0, 1'b1);
    wait_ev(1'b1);
    check(16'(period_match), 16'h0001);
    step(6);
    check(16'(count_value), 16'h0000);
    cfg(5'h18, 3'h0, 4'h0, 1'b0);
    wr(1'b1, 1'b0, 8'h10);
    cfg(5'h18, 3'h0, 4'h0, 1'b1);
    step(20);
    check(16'(count_value), 16'h0010);
  endtask
  // Active-high gate, then rising-edge reset with and without freeze
  task automatic t_ext();
    cfg(5'h01, 3'h0, 4'h0, 1'b0);
    wr(1'b0, 1'b1, 8'hFF);
    wr(1'b1, 1'b0, 8'h20);
    cfg(5'h01, 3'h0, 4'h0, 1'b1);
    step(20);
    check(16'(count_value), 16'h0020);
    want_level = 1'b1;
    step(20);
    check(16'(count_value > 8'h20), 16'h0001);
    check(16'(timer_tick), 16'h0001);
    want_level = 1'b0;
    cfg(5'h04, 3'h0, 4'h0, 1'b1);
    step(40);
    want_level = 1'b1;
    step(10);
    check(16'(count_value < 8'h10), 16'h0001);
    want_level = 1'b0;
    step(10);
    check(16'(count_value > 8'h0C), 16'h0001);
    debug_freeze = 1'b1;
    want_level = 1'b1;
    step(10);
    check(16'(count_value > 8'h14), 16'h0001);
  endtask
  initial begin
    step(12);
    rst = 1'b0;
    step(1);
    check(16'(count_value), 16'h0000);
    check(16'(period_value), 16'h00FF);
    wr(1'b0, 1'b1, 8'h02);
    wr(1'b1, 1'b0, 8'h37);
    check(16'(count_value), 16'h0037);
    t_scale();
    t_oneshot();
    t_ext();
    end_sim();
  end
endmodule // test_pth_timer
bind pth_timer pth_timer_chk u_pth_timer_chk (.clock(clock), .rst(rst), .sw_wr(sw_wr),
  .hw_limit_control_reg(hw_limit_control_reg), .run_enable_clr(run_enable_clr),
  .count_value(count_value), .period_value(period_value),
  .period_pulse_out(period_pulse_out));
